/* File: hdl/mac_pkg.sv */
// Package for the multiplexed converter serial control port.
// Assumes a 100 MHz system clock and a host-driven shift clock as the link clock.
package mac_pkg;
	localparam int CMD_W       = 4;
	localparam int ADDR_W      = 3;
	localparam int RES_W       = 12;
	localparam int CHAN_N      = 8;
	localparam int EN_POS      = 3;
	localparam int CLK_MHZ     = 100;
	localparam int BREAK_GAP_NS       = 125;
	localparam int ALL_OPEN_DELAY_NS  = 190;
	localparam int BREAK_GAP_CYC      = (BREAK_GAP_NS * CLK_MHZ + 999) / 1000;
	localparam int ALL_OPEN_DELAY_CYC = (ALL_OPEN_DELAY_NS * CLK_MHZ + 999) / 1000;
	// Five bits hold both delays in full; four bits would wrap the open delay.
	localparam logic [4:0] BREAK_GAP_CNT = 5'(BREAK_GAP_CYC);
	localparam logic [4:0] OPEN_CNT      = 5'(ALL_OPEN_DELAY_CYC);
	localparam logic [4:0] NULL_SLOT  = 5'h01;
	localparam logic [4:0] LAST_SLOT  = 5'h0c;
	localparam logic [4:0] SLOT_ZERO  = 5'h00;
	localparam logic [4:0] CNT_ZERO   = 5'h00;
	localparam logic [CHAN_N-1:0] ALL_OPEN = 8'h00;
	typedef enum logic [1:0] {
		MAC_IDLE  = 2'b00,
		MAC_OPEN  = 2'b01,
		MAC_CLOSE = 2'b10,
		MAC_HOLD  = 2'b11
	} mac_sw_e;
endpackage

/* File: hdl/mac_link_if.sv */
// Carries the command word and conversion result between the link logic and the switch control.
// Assumes the producer holds each word stable while the select level that announces it crosses.
`timescale 1ns/1ns
interface mac_link_if;
	import mac_pkg::*;
	logic [CMD_W-1:0] cmd;
	logic             sel_level;
	logic [RES_W-1:0] result;
	logic             result_tgl;
	modport link (output cmd, output sel_level, input result, input result_tgl);
	modport core (input cmd, input sel_level, output result, output result_tgl);
endinterface

/* File: hdl/mac_link.sv */
// Shift-clock domain logic: command shifter and serial result output.
// Assumes the host shift clock only toggles around frames, so control is taken
// back from the select pins asynchronously to the shift clock edges.
`timescale 1ns/1ns
module mac_link
	import mac_pkg::*;
(
	input  wire logic shift_clk,
	input  wire logic selector_select_n,
	input  wire logic converter_select_n,
	input  wire logic serial_in,
	output logic      serial_out,
	output logic      serial_out_en,
	mac_link_if.link  lnk
);
	// =========================================================
	// Command capture
	logic [CMD_W-1:0] shreg;
	logic [4:0]       slot;
	logic [RES_W-1:0] sh_out;

	always_ff @(posedge shift_clk) begin
		if (selector_select_n) begin
			shreg <= {shreg[CMD_W-2:0], serial_in}; // RULE4 RULE5 RULE1
		end
	end

	// The word freezes on the falling select; it is re-armed only by a high select.
	always_ff @(negedge selector_select_n) begin
		lnk.cmd <= shreg;
	end

	// The select level is handed over instead of a toggle: a toggle here would have
	// no reset of its own and would stay unknown for the whole run.
	assign lnk.sel_level = selector_select_n;

	// =========================================================
	// Result output
	always_ff @(negedge shift_clk or posedge converter_select_n) begin
		if (converter_select_n) begin
			slot          <= SLOT_ZERO; // RULE10
			serial_out    <= 1'b0;
			serial_out_en <= 1'b0; // RULE12 RULE25
			sh_out        <= '0;
		end else begin
			serial_out_en <= 1'b1; // RULE23 RULE17
			if (slot < LAST_SLOT + NULL_SLOT) begin
				slot <= slot + NULL_SLOT; // RULE16
			end
			if (slot == SLOT_ZERO) begin
				serial_out <= 1'b0; // RULE8
				sh_out     <= lnk.result;
			end else if (slot <= LAST_SLOT) begin
				serial_out <= sh_out[RES_W-1]; // RULE24 RULE1 RULE2
				sh_out     <= {sh_out[RES_W-2:0], 1'b0};
			end else begin
				serial_out <= 1'b0; // RULE18
			end
		end
	end
endmodule // mac_link

/* File: hdl/mac_ctrl.sv */
// Top of the multiplexed converter serial control port.
// Assumes clk_sys at 100 MHz and a host shift clock unrelated in phase.
//
// What this block and its host must do
// RULE1: Data changes after falling shift clock and is sampled on rising edge.
// RULE2: Command word comes in first, conversion result goes out afterward.
// RULE3: Host raises select to begin; new command accepted only after that.
// RULE4: While select is high each rising shift clock shifts serial input in.
// RULE5: Extra command bits are allowed; only the last four are kept.
// RULE6: Host lowers select before the next rising shift clock after last bit.
// RULE7: On falling select open all channels, wait a gap, then close selection.
// RULE8: After connecting, sample and convert; send one null bit then result. The code latches sample_code at the select fall, before connecting.
// RULE9: Selected channel stays connected until the next falling select.
// RULE10: Raising select ends the exchange and resets the serial interface.
// RULE11: Enable bit zero keeps all channels open until the next falling select.
// RULE12: High converter select powers down and releases the serial output.
// RULE13: Low converter select lets the converter sample and convert.
// RULE14: High selector select loads an address; low connects that channel.
// RULE15: Host normally drives both selects together as one chip select.
// RULE16: Shift clock times transfers and paces conversion steps.
// RULE17: Serial input and output may share one wire, giving three wires.
// RULE18: Converter powers down whenever it is not converting.
// RULE19: Each sample resolves to a twelve-bit unipolar result.
// RULE20: Multiplexer offers four or eight channels depending on variant.
// RULE21: First command bit enables the addressed channel; zero turns all off.
// RULE22: Next three bits are the channel address, most significant first.
// RULE23: Device drives shared data line after select falls, before sixth fall.
// RULE24: After the null bit twelve result bits go out MSB first per falling edge.
// RULE25: Serial output stays high impedance while select is high.
`timescale 1ns/1ns
module mac_ctrl
	import mac_pkg::*;
#(
	parameter int CHAN_USED = CHAN_N
) (
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic              shift_clk,
	input  wire logic              selector_select_n,
	input  wire logic              converter_select_n,
	input  wire logic              serial_in,
	input  wire logic [RES_W-1:0]  sample_code,
	output logic                   serial_out,
	output logic                   serial_out_en,
	output logic [CHAN_N-1:0]      channel_close,
	output logic [ADDR_W-1:0]      selected_address,
	output logic                   converter_powered,
	output logic                   selector_output_live
);
	// =========================================================
	// Link side
	mac_link_if lnk ();
	logic sout_i;
	logic soen_i;

	mac_link u_link (
		.shift_clk          (shift_clk),
		.selector_select_n  (selector_select_n),
		.converter_select_n (converter_select_n),
		.serial_in          (serial_in),
		.serial_out         (sout_i),
		.serial_out_en      (soen_i),
		.lnk                (lnk.link)
	);

	// The serial pins belong to the shift clock, so they pass straight out from
	// its flip-flops; retiming them on clk_sys would skew the host's sampling.
	assign serial_out    = sout_i;
	assign serial_out_en = soen_i;

	// =========================================================
	// Crossings into clk_sys
	logic       tgl_s1;
	logic       tgl_s2;
	logic       tgl_s3;
	logic       adc_s1;
	logic       adc_s2;
	logic       fall_evt;

	// The select stages reset to the idle high level, so no false fall follows reset.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tgl_s1 <= 1'b1;
			tgl_s2 <= 1'b1;
			tgl_s3 <= 1'b1;
			adc_s1 <= 1'b1;
			adc_s2 <= 1'b1;
		end else begin
			tgl_s1 <= lnk.sel_level;
			tgl_s2 <= tgl_s1;
			tgl_s3 <= tgl_s2;
			adc_s1 <= converter_select_n;
			adc_s2 <= adc_s1;
		end
	end
	assign fall_evt = tgl_s3 & ~tgl_s2;

	// =========================================================
	// Break-before-make switch sequence
	mac_sw_e          sw_state;
	logic [4:0]       sw_cnt;
	logic [CMD_W-1:0] cmd_held;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sw_state <= MAC_IDLE;
			sw_cnt   <= CNT_ZERO;
			cmd_held <= '0;
		end else if (fall_evt) begin
			sw_state <= MAC_OPEN; // RULE7
			sw_cnt   <= OPEN_CNT;
			cmd_held <= lnk.cmd; // RULE14
		end else begin
			case (sw_state)
				MAC_OPEN: begin
					if (sw_cnt == CNT_ZERO) begin
						sw_state <= MAC_CLOSE;
						sw_cnt   <= BREAK_GAP_CNT;
					end else begin
						sw_cnt <= sw_cnt - 5'h01;
					end
				end
				MAC_CLOSE: begin
					if (sw_cnt == CNT_ZERO) begin
						sw_state <= MAC_HOLD; // RULE9
					end else begin
						sw_cnt <= sw_cnt - 5'h01;
					end
				end
				MAC_HOLD: sw_state <= MAC_HOLD;
				MAC_IDLE: sw_state <= MAC_IDLE;
				default:  sw_state <= MAC_IDLE;
			endcase
		end
	end

	// =========================================================
	// Channel drive
	genvar gi;
	generate
		for (gi = 0; gi < CHAN_N; gi++) begin : g_chan
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					channel_close[gi] <= 1'b0;
				end else if (sw_state == MAC_HOLD && cmd_held[EN_POS] // RULE11 RULE21
						&& cmd_held[ADDR_W-1:0] == ADDR_W'(gi) && gi < CHAN_USED) begin
					channel_close[gi] <= 1'b1; // RULE22 RULE20
				end else begin
					channel_close[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			selected_address     <= '0;
			selector_output_live <= 1'b0;
		end else begin
			selected_address     <= cmd_held[ADDR_W-1:0];
			selector_output_live <= (channel_close != ALL_OPEN);
		end
	end

	// =========================================================
	// Converter power and result hand-off
	logic [RES_W-1:0] res_q;
	logic             res_tgl;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			converter_powered <= 1'b0;
			res_q             <= '0;
			res_tgl           <= 1'b0;
		end else begin
			converter_powered <= ~adc_s2 && sw_state == MAC_HOLD; // RULE18 RULE12 RULE13
			if (fall_evt) begin
				res_q   <= sample_code; // RULE19
				res_tgl <= ~res_tgl;
			end
		end
	end
	assign lnk.result     = res_q;
	assign lnk.result_tgl = res_tgl;
endmodule // mac_ctrl

/* File: bench/mac_host_model.sv */
// Host model: drives both selects together, the shift clock and the command bits.
// Assumes the shift clock stands still low outside frames, as a host port would.
`timescale 1ns/1ns
module mac_host_model (
	output logic      shift_clk,
	output logic      selector_select_n,
	output logic      converter_select_n,
	output logic      serial_in,
	input  wire logic serial_out,
	input  wire logic serial_out_en
);
	logic sel;
	assign selector_select_n  = sel;
	assign converter_select_n = sel;
	initial begin
		shift_clk = 1'b0;
		serial_in = 1'b0;
		// A low-to-high step at start-up gives the link side its reset edge.
		sel = 1'b0;
		#1 sel = 1'b1;
	end
	// Leading extra bits oppose the enable bit, so a shifter keeping the first four fails.
	task automatic frame(input logic [3:0] cmd, input int extra, output logic [12:0] got,
			output logic en_ok);
		en_ok = 1'b1;
		sel = 1'b1;
		#40;
		for (int i = extra + 3; i >= 0; i--) begin
			serial_in = (i < 4) ? cmd[i] : ~cmd[3];
			#7 shift_clk = 1'b1;
			#8 shift_clk = 1'b0;
		end
		#2 sel = 1'b0;
		serial_in = ~serial_in;
		// Long enough for the break-before-make sequence to close the channel.
		#400;
		for (int i = 13; i >= 0; i--) begin
			#7;
			if (i < 13) begin
				got[i] = serial_out;
				en_ok &= serial_out_en;
			end
			shift_clk = 1'b1;
			#8 shift_clk = 1'b0;
		end
		#20 sel = 1'b1;
	endtask
endmodule // mac_host_model

/* File: bench/mac_ctrl_asserts.sv */
// Checker for the converter control port; sees only the top-level ports.
// Assumes the host drives both selects together.
`timescale 1ns/1ns
module mac_ctrl_asserts
	import mac_pkg::*;
(
	input wire logic              clk_sys,
	input wire logic              rst,
	input wire logic              shift_clk,
	input wire logic              selector_select_n,
	input wire logic              converter_select_n,
	input wire logic              serial_in,
	input wire logic              serial_out,
	input wire logic              serial_out_en,
	input wire logic [RES_W-1:0]  sample_code,
	input wire logic [CHAN_N-1:0] channel_close,
	input wire logic [ADDR_W-1:0] selected_address,
	input wire logic              converter_powered,
	input wire logic              selector_output_live
);
	a_release_high: assert property (@(posedge clk_sys) disable iff (rst)
		converter_select_n |-> !serial_out_en) else $error("output driven while deselected");
	a_power_down: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(converter_select_n) |-> ##[1:4] !converter_powered) else $error("no power down");
	a_power_up: assert property (@(posedge clk_sys) disable iff (rst)
		$fell(converter_select_n) |-> ##[1:40] converter_powered) else $error("no power up");
	a_break_first: assert property (@(posedge clk_sys) disable iff (rst)
		(channel_close != 8'h00) && $changed(channel_close) |-> $past(channel_close) == 8'h00)
		else $error("make before break");
	a_open_on_fall: assert property (@(posedge clk_sys) disable iff (rst)
		$fell(selector_select_n) |-> ##[1:6] channel_close == 8'h00) else $error("not opened");
	a_hold_closed: assert property (@(posedge clk_sys) disable iff (rst)
		selector_select_n && $past(selector_select_n, 6) && ($past(channel_close) != 8'h00)
		|-> channel_close == $past(channel_close)) else $error("channel dropped");
	a_addr_match: assert property (@(posedge clk_sys) disable iff (rst)
		selector_select_n && (channel_close != 8'h00)
		|-> channel_close == (8'h01 << selected_address)) else $error("wrong channel");
	a_quiet_load: assert property (@(posedge shift_clk)
		selector_select_n |-> !serial_out_en) else $error("output driven while loading");
endmodule // mac_ctrl_asserts
bind mac_ctrl mac_ctrl_asserts u_chk (.*);

/* File: bench/testbench.sv */
// Self-checking bench for the converter control port with a host model on the link.
// Assumes a 100 MHz system clock; the link clock runs only inside host frames.
`timescale 1ns/1ns
module testbench;
	import mac_pkg::*;
	logic clk_sys = 1'b0, rst = 1'b1;
	logic [RES_W-1:0] sample_code = 12'h000;
	logic shift_clk, sel_mux_n, sel_conv_n, serial_in, serial_out, serial_out_en;
	logic converter_powered, selector_output_live, en_ok;
	logic [CHAN_N-1:0] channel_close;
	logic [ADDR_W-1:0] selected_address;
	logic [12:0] got;
	logic [12:0] idle_view;
	assign idle_view = {channel_close, selected_address, converter_powered, selector_output_live};
	int error_cnt = 0, checks_done = 0;
	// Row: command, extra leading bits, stand-in code, expected closed channel.
	logic [27:0] rows [9] = '{{4'h8,4'h0,12'h000,8'h01}, {4'h9,4'h2,12'hfff,8'h02},
		{4'ha,4'h0,12'h800,8'h04}, {4'hb,4'h1,12'h001,8'h08}, {4'hc,4'h0,12'h5a5,8'h10},
		{4'hd,4'h3,12'ha5a,8'h20}, {4'he,4'h0,12'h7ff,8'h40}, {4'hf,4'h0,12'h123,8'h80},
		{4'h7,4'h0,12'hc3c,8'h00}};
	always #5 clk_sys = ~clk_sys;
	mac_ctrl u_dut (.clk_sys(clk_sys), .rst(rst), .shift_clk(shift_clk),
		.selector_select_n(sel_mux_n), .converter_select_n(sel_conv_n),
		.serial_in(serial_in), .sample_code(sample_code), .serial_out(serial_out),
		.serial_out_en(serial_out_en), .channel_close(channel_close),
		.selected_address(selected_address), .converter_powered(converter_powered),
		.selector_output_live(selector_output_live));
	mac_host_model u_host (.shift_clk(shift_clk), .selector_select_n(sel_mux_n),
		.converter_select_n(sel_conv_n), .serial_in(serial_in), .serial_out(serial_out),
		.serial_out_en(serial_out_en));
	task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] seen);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#60000;
		error_cnt++;
		give_verdict();
	end
	initial begin
		repeat (2) @(posedge clk_sys);
		#1 rst = 1'b0;
		chk("idle", 13'h0, idle_view);
		for (int r = 0; r < 9; r++) begin
			@(posedge clk_sys) #1 sample_code = rows[r][19:8];
			u_host.frame(rows[r][27:24], int'(rows[r][23:20]), got, en_ok);
			#100;
			chk("result", {1'b0, rows[r][19:8]}, got);
			chk("drive", 13'h1, {12'h0, en_ok});
			chk("close", {5'h0, rows[r][7:0]}, {5'h0, channel_close});
			chk("live", {12'h0, |rows[r][7:0]}, {12'h0, selector_output_live});
		end
		// A reset in mid-run must clear the switch state, and the next frame must work.
		u_host.frame(4'hb, 0, got, en_ok);
		@(posedge clk_sys) #1 rst = 1'b1;
		repeat (2) @(posedge clk_sys);
		#1 rst = 1'b0;
		chk("reset", 13'h0, idle_view);
		u_host.frame(4'h9, 2, got, en_ok);
		#100;
		chk("again", 13'h2, {5'h0, channel_close});
		give_verdict();
	end
endmodule // testbench
